// ---- src/dcs_pkg.sv ----
// Contract
// - Code 224 gives logic module three output, 225 its inverse.
// - Code 226 gives logic module four output, 227 its inverse.
// - Codes 270 to 276 give inverse of local sources 70 to 76.
// - Code 282 high when axle positioning reports reference orientation reached.
// - Codes 320-322 give extension inputs or remote values; 520-522 their inverse.
// - Codes 525-534 give raw pins, ignoring local/remote selection.
// - Codes 537-545 give inverse of raw sources 525-533.
// - Codes 700-703, 710-713, 720-723 give process-data booleans; 730 bus emergency.
// - Drive accelerates only after a selected clockwise or anticlockwise start; command sets direction.
// - Three-wire start needs enable high plus a rising edge on a start input.
// - With three-wire enable on, start pulses are latched.
// - Enable going low releases latch and stops the drive.
// - Once started in three-wire mode, further start edges are ignored.
// - Pulse under 32 ms, or both starts within 32 ms, stops the drive.
// - Three-wire mode only for local/remote selection 5 or 46.
// - Fault state cleared by programming acknowledge or selected acknowledge signal.
// - Each timer input comes from a selectable source, processed by its mode.
// - Thermo-contact routes a selected input against threshold into temperature monitoring.
// - Configurations 230 and 430 choose speed or torque controller; switching monitored.
// - Codes 70-75 give local inputs, remote-replaceable except input one; 76 multifunction.
// - Code 6 is constant high, code 7 constant low.
`default_nettype none
package dcs_pkg;

    localparam int          CLK_HZ         = 100_000_000;
    localparam int          QUAL_TIME_MS   = 32;
    localparam int          QUAL_CYCLES    = (CLK_HZ / 1000) * QUAL_TIME_MS;
    localparam int          SRC_W          = 10;

    localparam logic [9:0]  SRC_ON         = 10'h006;
    localparam logic [9:0]  SRC_OFF        = 10'h007;
    localparam logic [9:0]  SRC_LOC_BASE   = 10'h046;
    localparam logic [9:0]  SRC_LOC_LAST   = 10'h04C;
    localparam logic [9:0]  SRC_LM3        = 10'h0E0;
    localparam logic [9:0]  SRC_LM3_N      = 10'h0E1;
    localparam logic [9:0]  SRC_LM4        = 10'h0E2;
    localparam logic [9:0]  SRC_LM4_N      = 10'h0E3;
    localparam logic [9:0]  SRC_LOCN_BASE  = 10'h10E;
    localparam logic [9:0]  SRC_LOCN_LAST  = 10'h114;
    localparam logic [9:0]  SRC_POS_REACH  = 10'h11A;
    localparam logic [9:0]  SRC_EXT_BASE   = 10'h140;
    localparam logic [9:0]  SRC_EXT_LAST   = 10'h142;
    localparam logic [9:0]  SRC_EXTN_BASE  = 10'h208;
    localparam logic [9:0]  SRC_EXTN_LAST  = 10'h20A;
    localparam logic [9:0]  SRC_HW_BASE    = 10'h20D;
    localparam logic [9:0]  SRC_HW_LAST    = 10'h216;
    localparam logic [9:0]  SRC_HWN_BASE   = 10'h219;
    localparam logic [9:0]  SRC_HWN_LAST   = 10'h221;
    localparam logic [9:0]  SRC_PDO1_BASE  = 10'h2BC;
    localparam logic [9:0]  SRC_PDO2_BASE  = 10'h2C6;
    localparam logic [9:0]  SRC_PDO3_BASE  = 10'h2D0;
    localparam logic [9:0]  SRC_BUS_EMCY   = 10'h2DA;

    localparam logic [7:0]  LR_3WIRE       = 8'h05;
    localparam logic [7:0]  LR_3WIRE_KP    = 8'h2E;
    localparam logic [9:0]  CFG_FOC_A      = 10'h0E6;
    localparam logic [9:0]  CFG_FOC_B      = 10'h1AE;

    // Raw pins: six local, multifunction digital, three extension
    typedef struct packed {
        logic [2:0] ext;
        logic       mfi;
        logic [5:0] loc;
    } dcs_pins_type;

    // Values of all non-pin sources
    typedef struct packed {
        logic [4:0] remote_loc;
        logic       remote_mfi;
        logic [2:0] remote_ext;
        logic       remote_sel;
        logic       lm3;
        logic       lm4;
        logic       pos_reached;
        logic [3:0] pdo1;
        logic [3:0] pdo2;
        logic [3:0] pdo3;
        logic       bus_emcy;
        logic [8:0] unused_pad;
    } dcs_srcs_type;

    // Source selections of each function input
    typedef struct packed {
        logic [9:0] start_cw;
        logic [9:0] start_ccw;
        logic [9:0] three_wire;
        logic [9:0] err_ack;
        logic [9:0] timer1;
        logic [9:0] timer2;
        logic [9:0] thermo;
        logic [9:0] nm_change;
    } dcs_sel_type;

    typedef enum logic [2:0] {
        DCS_IDLE,
        DCS_ARMED,
        DCS_QUAL,
        DCS_RUN,
        DCS_STOP
    } dcs_tw_state_type;

endpackage : dcs_pkg
`default_nettype wire

// ---- src/dcs_source_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcs_source_mux
    import dcs_pkg::*;
(
    input  wire logic [9:0]   i_sel,
    input  wire dcs_pins_type i_pins,
    input  wire dcs_srcs_type i_srcs,
    output logic              o_val
);

    logic [6:0] loc_val;
    logic [2:0] ext_val;
    logic [9:0] hw_val;
    logic [9:0] idx;

    // Local input one stays on its pin: tied to controller release
    assign loc_val[0] = i_pins.loc[0];
    genvar g;
    for (g = 1; g < 6; g++)
    begin : g_loc
        assign loc_val[g] = i_srcs.remote_sel ? i_srcs.remote_loc[g - 1] : i_pins.loc[g];
    end
    assign loc_val[6] = i_srcs.remote_sel ? i_srcs.remote_mfi : i_pins.mfi;
    assign ext_val    = i_srcs.remote_sel ? i_srcs.remote_ext : i_pins.ext;
    assign hw_val     = {i_pins.ext, i_pins.mfi, i_pins.loc};

    // Purely combinational, so a new selection acts at once
    always_comb
    begin
        idx   = 10'h000;
        o_val = 1'b0;
        if (i_sel == SRC_ON)
            o_val = 1'b1;
        else if (i_sel == SRC_OFF)
            o_val = 1'b0;
        else if (i_sel >= SRC_LOC_BASE && i_sel <= SRC_LOC_LAST)
        begin
            idx   = i_sel - SRC_LOC_BASE;
            o_val = loc_val[idx[2:0]];
        end
        else if (i_sel >= SRC_LOCN_BASE && i_sel <= SRC_LOCN_LAST)
        begin
            idx   = i_sel - SRC_LOCN_BASE;
            o_val = ~loc_val[idx[2:0]];
        end
        else if (i_sel == SRC_LM3)
            o_val = i_srcs.lm3;
        else if (i_sel == SRC_LM3_N)
            o_val = ~i_srcs.lm3;
        else if (i_sel == SRC_LM4)
            o_val = i_srcs.lm4;
        else if (i_sel == SRC_LM4_N)
            o_val = ~i_srcs.lm4;
        else if (i_sel == SRC_POS_REACH)
            o_val = i_srcs.pos_reached;
        else if (i_sel >= SRC_EXT_BASE && i_sel <= SRC_EXT_LAST)
        begin
            idx   = i_sel - SRC_EXT_BASE;
            o_val = ext_val[idx[1:0]];
        end
        else if (i_sel >= SRC_EXTN_BASE && i_sel <= SRC_EXTN_LAST)
        begin
            idx   = i_sel - SRC_EXTN_BASE;
            o_val = ~ext_val[idx[1:0]];
        end
        else if (i_sel >= SRC_HW_BASE && i_sel <= SRC_HW_LAST)
        begin
            idx   = i_sel - SRC_HW_BASE;
            o_val = hw_val[idx[3:0]];
        end
        else if (i_sel >= SRC_HWN_BASE && i_sel <= SRC_HWN_LAST)
        begin
            idx   = i_sel - SRC_HWN_BASE;
            o_val = ~hw_val[idx[3:0]];
        end
        else if (i_sel >= SRC_PDO1_BASE && i_sel <= SRC_PDO1_BASE + 10'h003)
        begin
            idx   = i_sel - SRC_PDO1_BASE;
            o_val = i_srcs.pdo1[idx[1:0]];
        end
        else if (i_sel >= SRC_PDO2_BASE && i_sel <= SRC_PDO2_BASE + 10'h003)
        begin
            idx   = i_sel - SRC_PDO2_BASE;
            o_val = i_srcs.pdo2[idx[1:0]];
        end
        else if (i_sel >= SRC_PDO3_BASE && i_sel <= SRC_PDO3_BASE + 10'h003)
        begin
            idx   = i_sel - SRC_PDO3_BASE;
            o_val = i_srcs.pdo3[idx[1:0]];
        end
        else if (i_sel == SRC_BUS_EMCY)
            o_val = i_srcs.bus_emcy;
    end

endmodule : dcs_source_mux
`default_nettype wire

// ---- src/dcs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcs_top
    import dcs_pkg::*;
#(
    parameter int QUAL_CNT = QUAL_CYCLES
)
(
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire dcs_pins_type i_pins,
    input  wire dcs_srcs_type i_srcs,
    input  wire dcs_sel_type  i_sel,
    input  wire logic [7:0]   i_local_remote,
    input  wire logic [9:0]   i_config,
    input  wire logic         i_prog_ack,
    input  wire logic         i_fault,
    input  wire logic         i_switch_ok,
    output logic              o_run,
    output logic              o_dir_ccw,
    output logic              o_stop_req,
    output logic              o_fault_active,
    output logic              o_timer1_in,
    output logic              o_timer2_in,
    output logic              o_thermo_trip,
    output logic              o_torque_mode,
    output logic              o_changeover_busy
);

    initial
    begin
        if (QUAL_CNT < 1)
            $error("QUAL_CNT must be at least one");
    end

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    dcs_pins_type s1_r;
    dcs_pins_type s2_r;
    dcs_pins_type s3_r;
    dcs_pins_type pins_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            pins_r <= '0;
        end
        else
        begin
            s1_r <= i_pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // Accept a bit only once two stages agree
            for (int k = 0; k < $bits(dcs_pins_type); k++)
            begin
                if (s2_r[k] == s3_r[k])
                    pins_r[k] <= s3_r[k];
            end
        end
    end

    // ********************************************************
    // Source selection
    // ********************************************************
    localparam int NFN = 8;
    logic [NFN-1:0] fn_val;
    logic [NFN-1:0][9:0] sel_arr;
    assign sel_arr = i_sel;

    genvar g;
    for (g = 0; g < NFN; g++)
    begin : g_mux
        dcs_source_mux u_mux (
            .i_sel  (sel_arr[g]),
            .i_pins (pins_r),
            .i_srcs (i_srcs),
            .o_val  (fn_val[g])
        );
    end

    // Packed order: index 7 is start_cw down to 0 nm_change
    logic cw;
    logic ccw;
    logic tw_en;
    logic ack;
    logic tm1;
    logic tm2;
    logic thermo;
    logic nm;
    assign {cw, ccw, tw_en, ack, tm1, tm2, thermo, nm} = fn_val;

    // ********************************************************
    // Start commands and three-wire control
    // ********************************************************
    logic three_wire_mode;
    assign three_wire_mode = (i_local_remote == LR_3WIRE) || (i_local_remote == LR_3WIRE_KP);

    logic cw_d_r;
    logic ccw_d_r;
    logic tw_en_d_r;
    logic cw_rise;
    logic ccw_rise;

    assign cw_rise  = cw & ~cw_d_r;
    assign ccw_rise = ccw & ~ccw_d_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cw_d_r    <= 1'b0;
            ccw_d_r   <= 1'b0;
            tw_en_d_r <= 1'b0;
        end
        else
        begin
            cw_d_r    <= cw;
            ccw_d_r   <= ccw;
            tw_en_d_r <= tw_en;
        end
    end

    dcs_tw_state_type tw_state_r;
    logic [31:0]      qual_cnt_r;
    logic             tw_dir_r;
    logic             tw_stop_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tw_state_r <= DCS_IDLE;
            qual_cnt_r <= 32'h0000_0000;
            tw_dir_r   <= 1'b0;
            tw_stop_r  <= 1'b0;
        end
        else if (!three_wire_mode)
        begin
            tw_state_r <= DCS_IDLE;
            qual_cnt_r <= 32'h0000_0000;
            tw_stop_r  <= 1'b0;
        end
        else
        begin
            tw_stop_r <= 1'b0;
            case (tw_state_r)
                DCS_IDLE:
                begin
                    if (tw_en)
                        tw_state_r <= DCS_ARMED;
                end
                DCS_ARMED:
                begin
                    if (!tw_en)
                        tw_state_r <= DCS_IDLE;
                    else if (cw_rise || ccw_rise)
                    begin
                        tw_dir_r   <= ccw_rise & ~cw_rise;
                        qual_cnt_r <= 32'h0000_0001;
                        // Simultaneous edges fail qualification at once
                        tw_state_r <= (cw_rise && ccw_rise) ? DCS_STOP : DCS_QUAL;
                    end
                end
                DCS_QUAL:
                begin
                    if (!tw_en)
                    begin
                        tw_state_r <= DCS_IDLE;
                        tw_stop_r  <= 1'b1;
                    end
                    else if (qual_cnt_r >= 32'(QUAL_CNT))
                        tw_state_r <= DCS_RUN;
                    else if ((tw_dir_r ? ~ccw : ~cw) || (tw_dir_r ? cw_rise : ccw_rise))
                        tw_state_r <= DCS_STOP;
                    else
                        qual_cnt_r <= qual_cnt_r + 32'h0000_0001;
                end
                DCS_RUN:
                begin
                    // Start edges are not looked at here
                    if (!tw_en)
                    begin
                        tw_state_r <= DCS_IDLE;
                        tw_stop_r  <= 1'b1;
                    end
                end
                DCS_STOP:
                begin
                    tw_stop_r <= 1'b1;
                    // Re-arm only after enable is cycled
                    if (!tw_en)
                        tw_state_r <= DCS_IDLE;
                end
                default:
                    tw_state_r <= DCS_IDLE;
            endcase
        end
    end

    // Running while qualifying keeps the latch behaviour visible at once
    logic tw_latched;
    assign tw_latched = (tw_state_r == DCS_QUAL) || (tw_state_r == DCS_RUN);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_run      <= 1'b0;
            o_dir_ccw  <= 1'b0;
            o_stop_req <= 1'b0;
        end
        else if (three_wire_mode)
        begin
            o_run      <= tw_latched;
            o_dir_ccw  <= tw_dir_r;
            o_stop_req <= tw_stop_r | (tw_en_d_r & ~tw_en);
        end
        else
        begin
            o_run      <= cw | ccw;
            o_dir_ccw  <= ccw & ~cw;
            o_stop_req <= o_run & ~(cw | ccw);
        end
    end

    // ********************************************************
    // Fault acknowledge
    // ********************************************************
    logic ack_d_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ack_d_r        <= 1'b0;
            o_fault_active <= 1'b0;
        end
        else
        begin
            ack_d_r <= ack;
            // New fault wins over a same-cycle acknowledge
            if (i_fault)
                o_fault_active <= 1'b1;
            else if (i_prog_ack || (ack && !ack_d_r))
                o_fault_active <= 1'b0;
        end
    end

    // ********************************************************
    // Timer, thermo-contact, speed/torque change-over
    // ********************************************************
    logic torque_req_r;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_timer1_in       <= 1'b0;
            o_timer2_in       <= 1'b0;
            o_thermo_trip     <= 1'b0;
            o_torque_mode     <= 1'b0;
            o_changeover_busy <= 1'b0;
            torque_req_r      <= 1'b0;
        end
        else
        begin
            o_timer1_in   <= tm1;
            o_timer2_in   <= tm2;
            o_thermo_trip <= thermo;
            if ((i_config == CFG_FOC_A) || (i_config == CFG_FOC_B))
            begin
                torque_req_r <= nm;
                // Hold change-over until the controller reports handover
                if (torque_req_r != o_torque_mode)
                begin
                    o_changeover_busy <= 1'b1;
                    if (i_switch_ok)
                    begin
                        o_torque_mode     <= torque_req_r;
                        o_changeover_busy <= 1'b0;
                    end
                end
                else
                    o_changeover_busy <= 1'b0;
            end
            else
            begin
                torque_req_r      <= 1'b0;
                o_torque_mode     <= 1'b0;
                o_changeover_busy <= 1'b0;
            end
        end
    end

endmodule : dcs_top
`default_nettype wire

// ---- bench/dcs_contact_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcs_contact_model
    import dcs_pkg::*;
#(
    parameter int MIN_HOLD = 4
)
(
    input  wire logic         i_clk,
    input  wire dcs_pins_type i_want,
    output dcs_pins_type      o_pins
);
    // ****************
    // Contact bank
    // ****************
    int hold [10];

    initial o_pins = '0;

    // A contact that moves stays put for a while; pulses never come shorter
    always @(posedge i_clk)
    begin
        for (int b = 0; b < 10; b++)
        begin
            if (hold[b] > 0)
                hold[b] <= hold[b] - 1;
            else if (i_want[b] != o_pins[b])
            begin
                o_pins[b] <= i_want[b];
                hold[b]   <= MIN_HOLD;
            end
        end
    end
endmodule : dcs_contact_model
`default_nettype wire

// ---- bench/dcs_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcs_top_sva
    import dcs_pkg::*;
#(
    parameter int QUAL_CNT = QUAL_CYCLES
)
(
    input wire logic         i_clk,
    input wire logic         i_rst_n,
    input wire dcs_pins_type i_pins,
    input wire dcs_srcs_type i_srcs,
    input wire dcs_sel_type  i_sel,
    input wire logic [7:0]   i_local_remote,
    input wire logic [9:0]   i_config,
    input wire logic         i_prog_ack,
    input wire logic         i_fault,
    input wire logic         i_switch_ok,
    input wire logic         o_run,
    input wire logic         o_dir_ccw,
    input wire logic         o_stop_req,
    input wire logic         o_fault_active,
    input wire logic         o_timer1_in,
    input wire logic         o_timer2_in,
    input wire logic         o_thermo_trip,
    input wire logic         o_torque_mode,
    input wire logic         o_changeover_busy
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Plain start mode, one direction source tied on at one edge, output checked one edge later
    sequence cw_only_s;
        (i_local_remote != LR_3WIRE) && (i_local_remote != LR_3WIRE_KP) && (i_sel.start_cw == SRC_ON) ##1 1'h1;
    endsequence
    sequence ccw_only_s;
        (i_local_remote != LR_3WIRE) && (i_local_remote != LR_3WIRE_KP) && (i_sel.start_ccw == SRC_ON)
            && (i_sel.start_cw == SRC_OFF) ##1 1'h1;
    endsequence
    property lvl_p(logic c, logic v);
        c ##1 1'h1 |-> v;
    endproperty

    start_cw_a: assert property (cw_only_s |-> o_run && !o_dir_ccw)
        else $error("clockwise start not followed");
    start_ccw_a: assert property (ccw_only_s |-> o_run && o_dir_ccw)
        else $error("anticlockwise start not followed");
    timer_on_a: assert property (lvl_p(i_sel.timer1 == SRC_ON, o_timer1_in))
        else $error("constant high source not delivered");
    timer_off_a: assert property (lvl_p(i_sel.timer2 == 10'h3FF, !o_timer2_in))
        else $error("unmapped source not low");
    thermo_inv_a: assert property (lvl_p(i_sel.thermo == SRC_LM3_N && !i_srcs.lm3, o_thermo_trip))
        else $error("inverted logic module source wrong");
    fault_set_a: assert property (i_fault |=> o_fault_active)
        else $error("fault not latched");
    fault_rise_a: assert property ($rose(o_fault_active) |-> $past(i_fault))
        else $error("fault flag set without fault");
    prog_clear_a: assert property (o_fault_active && i_prog_ack && !i_fault |=> !o_fault_active)
        else $error("acknowledge did not clear fault");
    stop_fall_a: assert property ($fell(o_run) |-> ##[0:1] o_stop_req)
        else $error("run dropped without stop request");
    torque_gate_a: assert property ($changed(o_torque_mode) |-> $past(i_switch_ok))
        else $error("controller switched without ready");
    torque_cfg_a: assert property ($rose(o_torque_mode)
        |-> ($past(i_config) == CFG_FOC_A) || ($past(i_config) == CFG_FOC_B))
        else $error("torque mode outside field oriented configuration");
    busy_drop_a: assert property ($fell(o_changeover_busy) |-> $past(i_switch_ok))
        else $error("change-over ended without ready");
endmodule : dcs_top_sva

bind dcs_top dcs_top_sva #(.QUAL_CNT(QUAL_CNT)) i_dcs_top_sva (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_pins(i_pins), .i_srcs(i_srcs), .i_sel(i_sel),
    .i_local_remote(i_local_remote), .i_config(i_config), .i_prog_ack(i_prog_ack), .i_fault(i_fault),
    .i_switch_ok(i_switch_ok), .o_run(o_run), .o_dir_ccw(o_dir_ccw), .o_stop_req(o_stop_req),
    .o_fault_active(o_fault_active), .o_timer1_in(o_timer1_in), .o_timer2_in(o_timer2_in),
    .o_thermo_trip(o_thermo_trip), .o_torque_mode(o_torque_mode), .o_changeover_busy(o_changeover_busy)
);
`default_nettype wire

// ---- bench/dcs_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %b seen %b", nm, e, g); end end
module dcs_top_tb
    import dcs_pkg::*;
;
    localparam int QC = 8;
    typedef struct {
        int   w;
        logic e;
    } dcs_note_type;

    logic         clk = 1'h0;
    logic         rst_n = 1'h0;
    dcs_pins_type want = '0;
    dcs_pins_type pins;
    dcs_srcs_type srcs = '0;
    dcs_sel_type  sel = '0;
    logic [7:0]   lr = 8'h00;
    logic [9:0]   cfg = 10'h000;
    logic         prog_ack = 1'h0;
    logic         fault = 1'h0;
    logic         sw_ok = 1'h0;
    wire  [8:0]   obs;
    int           n_errors = 0;
    int           check_count = 0;
    int           seed = 32;
    dcs_note_type notes[$];
    event         look;
    string        onm [9] = '{"run", "dir_ccw", "stop_req", "fault_active", "timer1_in", "timer2_in",
                              "thermo_trip", "torque_mode", "changeover_busy"};

    always #5 clk = ~clk;

    dcs_contact_model #(.MIN_HOLD(4)) i_dcs_contact_model (.i_clk(clk), .i_want(want), .o_pins(pins));

    dcs_top #(.QUAL_CNT(QC)) i_dcs_top (
        .i_clk(clk), .i_rst_n(rst_n), .i_pins(pins), .i_srcs(srcs), .i_sel(sel),
        .i_local_remote(lr), .i_config(cfg), .i_prog_ack(prog_ack), .i_fault(fault),
        .i_switch_ok(sw_ok), .o_run(obs[0]), .o_dir_ccw(obs[1]), .o_stop_req(obs[2]),
        .o_fault_active(obs[3]), .o_timer1_in(obs[4]), .o_timer2_in(obs[5]),
        .o_thermo_trip(obs[6]), .o_torque_mode(obs[7]), .o_changeover_busy(obs[8])
    );

    // ****************
    // Helpers
    // ****************
    function automatic logic ref_src(input int k, input dcs_pins_type p, input dcs_srcs_type s);
        if (k == 6)
            return 1'h1;
        // Input one stays on its pin: it carries controller release
        if (k >= 70 && k <= 76)
            return (k == 70 || !s.remote_sel) ? p[k - 70] : ((k == 76) ? s.remote_mfi : s.remote_loc[k - 71]);
        if ((k >= 270 && k <= 276) || (k >= 520 && k <= 522))
            return !ref_src(k - 200, p, s);
        if (k >= 224 && k <= 227)
            return (k < 226 ? s.lm3 : s.lm4) ^ k[0];
        if (k == 282)
            return s.pos_reached;
        if (k >= 320 && k <= 322)
            return s.remote_sel ? s.remote_ext[k - 320] : p.ext[k - 320];
        if (k >= 525 && k <= 534)
            return p[k - 525];
        if (k >= 537 && k <= 545)
            return !p[k - 537];
        if (k >= 700 && k <= 703)
            return s.pdo1[k - 700];
        if (k >= 710 && k <= 713)
            return s.pdo2[k - 710];
        if (k >= 720 && k <= 723)
            return s.pdo3[k - 720];
        return (k == 730) ? s.bus_emcy : 1'h0;
    endfunction : ref_src

    task automatic note(input int w, input logic e);
        notes.push_back('{w, e});
        ->look;
    endtask : note

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // Bit0 cw, bit1 ccw, bit2 three-wire enable, bit3 acknowledge
    task automatic step(input logic [3:0] v, input int n);
        @(posedge clk);
        srcs.pdo1 <= v;
        settle(n);
    endtask : step

    task automatic report_and_stop();
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // ****************
    // Checking and stimulus
    // ****************
    initial
    begin : watch
        dcs_note_type n;
        forever
        begin
            @(look);
            while (notes.size() > 0)
            begin
                n = notes.pop_front();
                `CHK(onm[n.w], n.e, obs[n.w])
            end
        end
    end

    initial
    begin : watchdog
        #200_000;
        n_errors++;
        report_and_stop();
    end

    initial
    begin : main
        dcs_srcs_type rs;
        logic         e;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        settle(2);
        for (int r = 0; r < 2; r++)
        begin
            rs = dcs_srcs_type'(35'({$random(seed), $random(seed)}));
            rs.remote_sel = r[0];
            @(posedge clk);
            want <= dcs_pins_type'(10'($random(seed)));
            srcs <= rs;
            repeat (12) @(posedge clk);
            for (int c = 0; c < 1024; c++)
            begin
                sel.timer1 <= 10'(c);
                sel.timer2 <= 10'(c);
                sel.thermo <= 10'(c);
                settle(2);
                e = ref_src(c, want, rs);
                for (int k = 4; k < 7; k++) note(k, e);
                @(posedge clk);
            end
        end
        @(posedge clk);
        srcs <= '0;
        lr   <= LR_3WIRE;
        sel  <= '{SRC_PDO1_BASE, SRC_PDO1_BASE + 10'h001, SRC_PDO1_BASE + 10'h002, SRC_PDO1_BASE + 10'h003,
                  SRC_ON, 10'h3FF, SRC_LM3_N, SRC_OFF};
        step(4'h4, 3);
        step(4'h5, 3);
        note(0, 1'h1);
        note(1, 1'h0);
        step(4'h5, QC + 4);
        step(4'h4, 3);
        note(0, 1'h1);
        step(4'h6, QC + 4);
        note(0, 1'h1);
        note(1, 1'h0);
        step(4'h4, 3);
        step(4'h0, 3);
        note(0, 1'h0);
        step(4'h4, 3);
        step(4'h6, 3);
        step(4'h4, QC + 4);
        note(0, 1'h0);
        note(2, 1'h1);
        step(4'h0, 3);
        step(4'h4, 3);
        step(4'h5, 2);
        step(4'h7, QC + 4);
        note(0, 1'h0);
        step(4'h0, 3);
        @(posedge clk);
        lr <= LR_3WIRE_KP;
        step(4'h4, 3);
        step(4'h6, QC + 4);
        note(0, 1'h1);
        note(1, 1'h1);
        step(4'h0, 3);
        note(0, 1'h0);
        // Enable stays high here: outside three-wire modes nothing may latch
        @(posedge clk);
        lr <= 8'h00;
        step(4'h4, 2);
        @(posedge clk);
        sel.start_cw <= SRC_ON;
        settle(3);
        note(0, 1'h1);
        note(1, 1'h0);
        @(posedge clk);
        sel.start_cw  <= SRC_OFF;
        sel.start_ccw <= SRC_ON;
        settle(3);
        note(0, 1'h1);
        note(1, 1'h1);
        @(posedge clk);
        sel.start_ccw <= SRC_PDO1_BASE + 10'h001;
        settle(3);
        note(0, 1'h0);
        @(posedge clk);
        fault <= 1'h1;
        @(posedge clk);
        fault <= 1'h0;
        settle(2);
        note(3, 1'h1);
        @(posedge clk);
        prog_ack <= 1'h1;
        @(posedge clk);
        prog_ack <= 1'h0;
        settle(2);
        note(3, 1'h0);
        @(posedge clk);
        fault <= 1'h1;
        @(posedge clk);
        fault <= 1'h0;
        step(4'h8, 3);
        note(3, 1'h0);
        @(posedge clk);
        cfg           <= CFG_FOC_A;
        sel.nm_change <= SRC_ON;
        settle(3);
        note(8, 1'h1);
        note(7, 1'h0);
        @(posedge clk);
        sw_ok <= 1'h1;
        settle(3);
        note(7, 1'h1);
        note(8, 1'h0);
        @(posedge clk);
        cfg           <= CFG_FOC_B;
        sel.nm_change <= SRC_OFF;
        settle(4);
        note(7, 1'h0);
        @(posedge clk);
        cfg           <= 10'h000;
        sel.nm_change <= SRC_ON;
        settle(4);
        note(7, 1'h0);
        settle(2);
        report_and_stop();
    end
endmodule : dcs_top_tb
`default_nettype wire
